// *** rtl/sbcspi_regs.svh ***
// Register offsets, field positions and reset values of the serial control port
`ifndef SBCSPI_REGS_SVH
`define SBCSPI_REGS_SVH

`define SBCSPI_FRAME_BITS      5'd16
`define SBCSPI_CTRL_LAST       7'h1e
`define SBCSPI_STAT_FIRST      7'h40
`define SBCSPI_STAT_LAST       7'h7e

`define SBCSPI_MODE_CTRL       7'h01
`define SBCSPI_WDOG_CTRL       7'h03
`define SBCSPI_BUS_CTRL        7'h04
`define SBCSPI_HS_CTRL_ONE     7'h14
`define SBCSPI_HS_CTRL_TWO     7'h15

`define SBCSPI_SUP_STAT_TWO    7'h40
`define SBCSPI_SUP_STAT_ONE    7'h41
`define SBCSPI_THERMAL_STATUS      7'h42
`define SBCSPI_DEVICE_STATUS        7'h43
`define SBCSPI_BUS_STAT        7'h44
`define SBCSPI_WAKE_STAT_ONE   7'h46
`define SBCSPI_WAKE_STAT_TWO   7'h47
`define SBCSPI_WAKE_LEVEL      7'h48
`define SBCSPI_SELWAKE_FIRST   7'h70
`define SBCSPI_SELWAKE_LAST    7'h77
`define SBCSPI_HS_OVL_STAT     7'h54
`define SBCSPI_HS_OPEN_STAT    7'h55
`define SBCSPI_FAMILY_ID       7'h7e

`define SBCSPI_MODE_FIELD_MSB  7
`define SBCSPI_MODE_FIELD_LSB  6
`define SBCSPI_REG2_SA_BIT     3
`define SBCSPI_FAILOUT_BIT     0
`define SBCSPI_SPI_FAIL_BIT    2
`define SBCSPI_BUS_MODE_MSB    1
`define SBCSPI_BUS_MODE_LSB    0
`define SBCSPI_BUS_MODE_OFF    2'b00
`define SBCSPI_BUS_MODE_WAKE   2'b01

`define SBCSPI_REG_RESET       8'h00
`define SBCSPI_FAMILY_VALUE    8'h5a

`endif

// *** rtl/sbcspi_pkg.sv ***
// Types shared by the serial control port
package sbcspi_pkg;

  typedef enum logic [2:0] {
    SBCSPI_MODE_INIT     = 3'b000,
    SBCSPI_MODE_NORMAL   = 3'b001,
    SBCSPI_MODE_STOP     = 3'b010,
    SBCSPI_MODE_SLEEP    = 3'b011,
    SBCSPI_MODE_RESTART  = 3'b100,
    SBCSPI_MODE_FAILSAFE = 3'b101
  } sbcspi_mode_t;

  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
    logic [7:0] bits;
  } sbcspi_hw_upd_t;

  typedef struct packed {
    logic [7:0] data;
    logic       clear_sel;
    logic [6:0] addr;
  } sbcspi_frame_t;

endpackage

// *** rtl/sbcspi_port.sv ***
// Serial control port: framing, register file, status summary and mode effects
`include "sbcspi_regs.svh"

module sbcspi_port #(
  parameter int NUM_CTRL = 31
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   nrst_i,
  input  wire logic                   spi_clk_i,
  input  wire logic                   chip_select_n_i,
  input  wire logic                   serial_in_i,
  output logic                        serial_out_o,
  output logic                        serial_out_oe_o,
  input  wire sbcspi_pkg::sbcspi_mode_t mode_i,
  input  wire sbcspi_pkg::sbcspi_hw_upd_t stat_set_i,
  input  wire sbcspi_pkg::sbcspi_hw_upd_t live_upd_i,
  input  wire logic [7:0]             wake_pin_level_i,
  output logic                        mode_req_valid_o,
  output logic [1:0]                  mode_req_o,
  output logic [NUM_CTRL*8-1:0]       ctrl_regs_o,
  output logic [7:0]                  status_summary_o
);

  // Identity value is arbitrary
  localparam logic [7:0] FAMILY_VALUE = `SBCSPI_FAMILY_VALUE;

  function automatic logic is_ctrl(input logic [6:0] a);
    return a <= `SBCSPI_CTRL_LAST;
  endfunction

  function automatic logic is_stat(input logic [6:0] a);
    return (a >= `SBCSPI_STAT_FIRST) && (a <= `SBCSPI_STAT_LAST);
  endfunction

  function automatic logic is_live(input logic [6:0] a);
    return (a == `SBCSPI_WAKE_LEVEL) || (a == `SBCSPI_FAMILY_ID) ||
           ((a >= `SBCSPI_SELWAKE_FIRST) && (a <= `SBCSPI_SELWAKE_LAST));
  endfunction

  // Pin synchronisers
  logic [1:0] sclk_sync_r;
  logic [1:0] csn_sync_r;
  logic [1:0] sdi_sync_r;
  logic       sclk_d_r;
  logic       csn_d_r;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      sclk_sync_r <= 2'b00;
      csn_sync_r  <= 2'b11;
      sdi_sync_r  <= 2'b00;
      sclk_d_r    <= 1'b0;
      csn_d_r     <= 1'b1;
    end else begin
      sclk_sync_r <= {sclk_sync_r[0], spi_clk_i};
      csn_sync_r  <= {csn_sync_r[0], chip_select_n_i};
      sdi_sync_r  <= {sdi_sync_r[0], serial_in_i};
      sclk_d_r    <= sclk_sync_r[1];
      csn_d_r     <= csn_sync_r[1];
    end
  end

  // Wake pins are asynchronous levels
  logic [7:0] wake_lvl_meta_r;
  logic [7:0] wake_lvl_sync_r;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      wake_lvl_meta_r <= 8'h00;
      wake_lvl_sync_r <= 8'h00;
    end else begin
      wake_lvl_meta_r <= wake_pin_level_i;
      wake_lvl_sync_r <= wake_lvl_meta_r;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic csn_fall;
  logic csn_rise;
  logic in_frame;
  logic restart;

  assign sclk_rise = sclk_sync_r[1] & ~sclk_d_r;
  assign sclk_fall = ~sclk_sync_r[1] & sclk_d_r;
  assign csn_fall  = ~csn_sync_r[1] & csn_d_r;
  assign csn_rise  = csn_sync_r[1] & ~csn_d_r;
  assign in_frame  = ~csn_sync_r[1];
  assign restart   = (mode_i == sbcspi_pkg::SBCSPI_MODE_RESTART);

  // Framing state
  logic [4:0]                fall_cnt_r;
  logic [4:0]                rise_cnt_r;
  logic [15:0]               rx_r;
  logic                      frame_bad_r;
  logic                      err_flag_r;
  logic [15:0]               tx_r;
  logic                      rd_loaded_r;
  logic                      exec_r;
  sbcspi_pkg::sbcspi_frame_t cmd_r;
  logic [7:0]                regs_r [0:127];
  logic [7:0]                summary_nxt;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      fall_cnt_r  <= 5'd0;
      rx_r        <= 16'h0000;
      frame_bad_r <= 1'b0;
    end else if (csn_fall) begin
      fall_cnt_r  <= 5'd0;
      frame_bad_r <= sclk_sync_r[1] | restart;
    end else if (in_frame) begin
      if (sclk_fall) begin
        if (fall_cnt_r < `SBCSPI_FRAME_BITS) begin
          rx_r[fall_cnt_r[3:0]] <= sdi_sync_r[1];
        end
        // Saturate so a long burst cannot wrap back to sixteen
        if (fall_cnt_r != 5'h1f) begin
          fall_cnt_r <= fall_cnt_r + 5'd1;
        end
      end
      if (restart) begin
        frame_bad_r <= 1'b1;
      end
    end
  end

  // Error flag reported at the opening of the next frame
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      err_flag_r <= 1'b0;
      exec_r     <= 1'b0;
      cmd_r      <= '0;
    end else begin
      exec_r <= 1'b0;
      if (csn_rise) begin
        if (frame_bad_r || sclk_sync_r[1] ||
            ((fall_cnt_r != 5'd0) && (fall_cnt_r != `SBCSPI_FRAME_BITS))) begin
          err_flag_r <= 1'b1;
        end else if (fall_cnt_r == `SBCSPI_FRAME_BITS) begin
          exec_r <= 1'b1;
          cmd_r  <= rx_r;
        end
      end else if (csn_fall) begin
        err_flag_r <= restart;
      end
    end
  end

  // Response shifter; data byte loaded once the address is in
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      tx_r            <= 16'h0000;
      rd_loaded_r     <= 1'b0;
      rise_cnt_r      <= 5'd0;
      serial_out_o    <= 1'b0;
      serial_out_oe_o <= 1'b0;
    end else if (csn_fall) begin
      tx_r            <= {8'h00, summary_nxt};
      rd_loaded_r     <= 1'b0;
      rise_cnt_r      <= 5'd0;
      serial_out_o    <= err_flag_r | restart;
      serial_out_oe_o <= 1'b1;
    end else if (in_frame) begin
      if (!rd_loaded_r && (fall_cnt_r >= 5'd7)) begin
        rd_loaded_r <= 1'b1;
        // Unmapped addresses answer zero
        if (is_ctrl(rx_r[6:0]) || is_stat(rx_r[6:0])) begin
          tx_r[15:8] <= regs_r[rx_r[6:0]];
        end
      end
      if (restart) begin
        serial_out_o <= 1'b1;
      end else if (sclk_rise && (rise_cnt_r < `SBCSPI_FRAME_BITS)) begin
        serial_out_o <= tx_r[rise_cnt_r[3:0]];
        rise_cnt_r   <= rise_cnt_r + 5'd1;
      end
    end else begin
      serial_out_o    <= 1'b0;
      serial_out_oe_o <= 1'b0;
    end
  end

  // Command classification
  logic cmd_ctrl;
  logic cmd_stat;
  logic cmd_write;
  logic cmd_stuck;
  logic cmd_mode_reg;
  logic [1:0] req_mode;
  logic bad_mode_req;
  logic stop_blocked;
  logic cmd_invalid;
  logic do_write;
  logic do_clear;

  assign cmd_ctrl     = is_ctrl(cmd_r.addr);
  assign cmd_stat     = is_stat(cmd_r.addr);
  assign cmd_write    = cmd_r.clear_sel & cmd_ctrl;
  assign cmd_stuck    = (cmd_r == 16'h0000) || (cmd_r == 16'hffff);
  assign cmd_mode_reg = (cmd_r.addr == `SBCSPI_MODE_CTRL);
  assign req_mode     = cmd_r.data[`SBCSPI_MODE_FIELD_MSB:`SBCSPI_MODE_FIELD_LSB];
  // Field code 01 asks for sleep, 10 for stop
  assign bad_mode_req = cmd_mode_reg && (
                          ((mode_i == sbcspi_pkg::SBCSPI_MODE_STOP) && (req_mode == 2'b01)) ||
                          ((mode_i == sbcspi_pkg::SBCSPI_MODE_INIT) && (req_mode != 2'b00)));
  assign stop_blocked = (mode_i == sbcspi_pkg::SBCSPI_MODE_STOP) && !cmd_mode_reg &&
                        (cmd_r.addr != `SBCSPI_WDOG_CTRL);
  assign cmd_invalid  = cmd_stuck | (cmd_write & (bad_mode_req | stop_blocked));
  assign do_write     = exec_r & cmd_write & ~cmd_invalid & ~restart;
  assign do_clear     = exec_r & cmd_r.clear_sel & cmd_stat & ~cmd_stuck &
                        ~is_live(cmd_r.addr) & ~restart;

  // Mode request handed to the mode state machine
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      mode_req_valid_o <= 1'b0;
      mode_req_o       <= 2'b00;
    end else begin
      mode_req_valid_o <= do_write & cmd_mode_reg;
      if (do_write & cmd_mode_reg) begin
        mode_req_o <= req_mode;
      end
    end
  end

  // Mode change tracking
  sbcspi_pkg::sbcspi_mode_t mode_d_r;
  logic                     mode_chg;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      mode_d_r <= sbcspi_pkg::SBCSPI_MODE_INIT;
    end else begin
      mode_d_r <= mode_i;
    end
  end

  assign mode_chg = (mode_i != mode_d_r);

  function automatic logic [1:0] mode_code(input sbcspi_pkg::sbcspi_mode_t m);
    case (m)
      sbcspi_pkg::SBCSPI_MODE_SLEEP: mode_code = 2'b01;
      sbcspi_pkg::SBCSPI_MODE_STOP:  mode_code = 2'b10;
      sbcspi_pkg::SBCSPI_MODE_RESTART,
      sbcspi_pkg::SBCSPI_MODE_FAILSAFE: mode_code = 2'b11;
      default: mode_code = 2'b00;
    endcase
  endfunction

  // Register file; hardware sets win over host clears
  logic [1:0] bus_mode;
  assign bus_mode = regs_r[`SBCSPI_BUS_CTRL][`SBCSPI_BUS_MODE_MSB:`SBCSPI_BUS_MODE_LSB];

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 128; i++) begin
        regs_r[i] <= `SBCSPI_REG_RESET;
      end
    end else begin
      for (int i = 0; i < 128; i++) begin
        logic [7:0] v;
        logic [7:0] set_m;
        v     = regs_r[i];
        set_m = 8'h00;
        if (do_write && (cmd_r.addr == 7'(i))) begin
          v = cmd_r.data;
        end
        if (do_clear && (cmd_r.addr == 7'(i))) begin
          v = 8'h00;
        end
        if (stat_set_i.valid && (stat_set_i.addr == 7'(i)) && !is_live(7'(i))) begin
          set_m = stat_set_i.bits;
        end
        if (exec_r && cmd_invalid && (i == `SBCSPI_DEVICE_STATUS)) begin
          set_m[`SBCSPI_SPI_FAIL_BIT] = 1'b1;
        end
        if (mode_chg) begin
          if (i == `SBCSPI_MODE_CTRL) begin
            v[`SBCSPI_MODE_FIELD_MSB:`SBCSPI_MODE_FIELD_LSB] = mode_code(mode_i);
          end
          // Stop leaves bus control as is
          if ((mode_i == sbcspi_pkg::SBCSPI_MODE_SLEEP) && (i == `SBCSPI_BUS_CTRL) &&
              (bus_mode != `SBCSPI_BUS_MODE_OFF) && (bus_mode != `SBCSPI_BUS_MODE_WAKE)) begin
            v[`SBCSPI_BUS_MODE_MSB:`SBCSPI_BUS_MODE_LSB] = `SBCSPI_BUS_MODE_WAKE;
          end
          if (mode_i == sbcspi_pkg::SBCSPI_MODE_RESTART) begin
            if ((i == `SBCSPI_HS_CTRL_ONE) || (i == `SBCSPI_HS_CTRL_TWO)) begin
              v = 8'h00;
            end
            if (i == `SBCSPI_MODE_CTRL) begin
              v[`SBCSPI_REG2_SA_BIT] = 1'b0;
            end
          end
        end
        regs_r[i] <= v | set_m;
      end
      // Mirrors of pin levels, fixed values and live hardware updates
      regs_r[`SBCSPI_WAKE_LEVEL] <= wake_lvl_sync_r;
      regs_r[`SBCSPI_FAMILY_ID]  <= FAMILY_VALUE;
      if (live_upd_i.valid && is_live(live_upd_i.addr) &&
          (live_upd_i.addr != `SBCSPI_WAKE_LEVEL) &&
          (live_upd_i.addr != `SBCSPI_FAMILY_ID)) begin
        regs_r[live_upd_i.addr] <= live_upd_i.bits;
      end
    end
  end

  // Summary from the current register contents
  always_comb begin
    summary_nxt[0] = |regs_r[`SBCSPI_SUP_STAT_ONE];
    summary_nxt[1] = |regs_r[`SBCSPI_THERMAL_STATUS];
    summary_nxt[2] = |regs_r[`SBCSPI_DEVICE_STATUS];
    summary_nxt[3] = |regs_r[`SBCSPI_BUS_STAT];
    summary_nxt[4] = |(regs_r[`SBCSPI_WAKE_STAT_ONE] | regs_r[`SBCSPI_WAKE_STAT_TWO]);
    summary_nxt[5] = |regs_r[`SBCSPI_SUP_STAT_TWO];
    summary_nxt[6] = |regs_r[`SBCSPI_HS_OVL_STAT];
    summary_nxt[7] = |regs_r[`SBCSPI_HS_OPEN_STAT];
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      status_summary_o <= 8'h00;
    end else begin
      status_summary_o <= summary_nxt;
    end
  end

  // Control bytes steer the rest of the chip; registered copies, fail output bit treated like the rest
  genvar g;
  generate
    for (g = 0; g < NUM_CTRL; g++) begin : g_ctrl
      always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
          ctrl_regs_o[g*8 +: 8] <= `SBCSPI_REG_RESET;
        end else begin
          ctrl_regs_o[g*8 +: 8] <= regs_r[g];
        end
      end
    end
  endgenerate

endmodule

// *** verification/sbcspi_port_assertions.sv ***
// Concurrent checks on the serial control port pins
module sbcspi_port_assertions #(
  parameter int NUM_CTRL = 31
) (
  input wire logic                      core_clk_i,
  input wire logic                      nrst_i,
  input wire logic                      chip_select_n_i,
  input wire logic                      serial_out_o,
  input wire logic                      serial_out_oe_o,
  input wire sbcspi_pkg::sbcspi_mode_t  mode_i,
  input wire sbcspi_pkg::sbcspi_hw_upd_t stat_set_i,
  input wire logic                      mode_req_valid_o,
  input wire logic [NUM_CTRL*8-1:0]     ctrl_regs_o,
  input wire logic [7:0]                status_summary_o
);
  logic [7:0] idle_r;

  // Cycles since the pin rose, saturating so long idle never passes for a recent frame end
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || !chip_select_n_i) begin
      idle_r <= 8'h00;
    end else if (idle_r != 8'hff) begin
      idle_r <= idle_r + 8'h01;
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence restart_hold_s;
    (mode_i == sbcspi_pkg::SBCSPI_MODE_RESTART)[*6];
  endsequence
  sequence restart_frame_s;
    (mode_i == sbcspi_pkg::SBCSPI_MODE_RESTART && serial_out_oe_o)[*4];
  endsequence

  oe_on_a: assert property ($fell(chip_select_n_i) |-> ##[2:5] serial_out_oe_o)
    else $error("output enable late after select");
  oe_off_a: assert property ($rose(chip_select_n_i) |-> ##[2:5] !serial_out_oe_o)
    else $error("output not released after select");
  idle_out_a: assert property (!serial_out_oe_o |-> !serial_out_o)
    else $error("output active while released");
  restart_out_a: assert property (restart_frame_s |-> serial_out_o)
    else $error("output not high in restart frame");
  restart_clear_a: assert property (restart_hold_s |->
      ctrl_regs_o[167:160] == 8'h00 && ctrl_regs_o[175:168] == 8'h00)
    else $error("switch config kept in restart");
  sum_supply_a: assert property (stat_set_i.valid && stat_set_i.addr == 7'h41 &&
      stat_set_i.bits != 8'h00 |-> ##[1:3] status_summary_o[0])
    else $error("supply summary bit not set");
  sum_wake_a: assert property (stat_set_i.valid && stat_set_i.addr == 7'h47 &&
      stat_set_i.bits != 8'h00 |-> ##[1:3] status_summary_o[4])
    else $error("wake summary bit not set");
  sum_open_a: assert property (stat_set_i.valid && stat_set_i.addr == 7'h55 &&
      stat_set_i.bits != 8'h00 |-> ##[1:3] status_summary_o[7])
    else $error("open load summary bit not set");
  sum_hold_a: assert property (|($past(status_summary_o) & ~status_summary_o) |->
      idle_r < 8'h14)
    else $error("summary bit dropped without a frame");
  mode_pulse_a: assert property (mode_req_valid_o |->
      idle_r >= 8'h02 && idle_r <= 8'h0c ##1 !mode_req_valid_o)
    else $error("mode request not a pulse after frame end");
endmodule

bind sbcspi_port sbcspi_port_assertions #(.NUM_CTRL(NUM_CTRL)) sbcspi_port_assertions_i (
  .core_clk_i, .nrst_i, .chip_select_n_i, .serial_out_o, .serial_out_oe_o, .mode_i,
  .stat_set_i, .mode_req_valid_o, .ctrl_regs_o, .status_summary_o);

// *** verification/sbcspi_host.sv ***
// Host serial master model sending frames with an 80 ns bit clock
module sbcspi_host (
  output logic      spi_clk_o,
  output logic      chip_select_n_o,
  output logic      serial_in_o,
  input  wire logic serial_out_i
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    spi_clk_o = 1'b0;
    chip_select_n_o = 1'b1;
    serial_in_o = 1'b0;
  end

  // Clock idles low at both select edges; offset keeps edges off the core clock
  task automatic frame(input logic [15:0] word, input int nclk,
                       output logic [15:0] resp, output logic err);
    resp = 16'h0000;
    #3 chip_select_n_o = 1'b0;
    #80 err = serial_out_i;
    // Data moves on the rising edge so it stands across the sampling fall
    for (int i = 0; i < nclk; i++) begin
      #40 spi_clk_o = 1'b1;
      serial_in_o = word[i];
      #40 resp[i] = serial_out_i;
      spi_clk_o = 1'b0;
    end
    #80 chip_select_n_o = 1'b1;
    // Released line must not keep showing the last bit
    serial_in_o = ~serial_in_o;
    #160;
  endtask
endmodule

// *** verification/test_sbcspi_port.sv ***
// Self-checking bench of the serial control port against the host model
`include "sbcspi_regs.svh"
module test_sbcspi_port;
  timeunit 1ns;
  timeprecision 100ps;
  logic                       core_clk_i = 1'b0;
  logic                       nrst_i = 1'b0;
  logic                       spi_clk;
  logic                       cs_n;
  logic                       serial_in;
  logic                       serial_out;
  logic                       sdo_oe;
  logic                       req_valid;
  logic [1:0]                 req;
  logic [31*8-1:0]            ctrl_regs;
  logic [7:0]                 summary;
  logic [7:0]                 level = 8'h00;
  sbcspi_pkg::sbcspi_mode_t   mode = sbcspi_pkg::SBCSPI_MODE_INIT;
  sbcspi_pkg::sbcspi_hw_upd_t stat_set = '0;
  sbcspi_pkg::sbcspi_hw_upd_t live_upd = '0;
  int                         n_mismatch = 0;
  int                         samples_checked = 0;
  int                         cycles = 0;
  logic [31:0]                seed = 32'd70441;
  logic [15:0]                resp;
  logic                       err;
  logic [7:0]                 v;
  logic [7:0]                 w;
  logic [6:0] stat_addr [9] = '{7'h41, 7'h42, 7'h43, 7'h44, 7'h46, 7'h47, 7'h40, 7'h54, 7'h55};
  int         stat_bit [9]  = '{0, 1, 2, 3, 4, 4, 5, 6, 7};

  sbcspi_port sbcspi_port_i (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .spi_clk_i(spi_clk),
    .chip_select_n_i(cs_n), .serial_in_i(serial_in), .serial_out_o(serial_out), .serial_out_oe_o(sdo_oe),
    .mode_i(mode), .stat_set_i(stat_set), .live_upd_i(live_upd), .wake_pin_level_i(level),
    .mode_req_valid_o(req_valid), .mode_req_o(req), .ctrl_regs_o(ctrl_regs),
    .status_summary_o(summary));
  sbcspi_host sbcspi_host_i (.spi_clk_o(spi_clk), .chip_select_n_o(cs_n), .serial_in_o(serial_in),
    .serial_out_i(serial_out));

  always #5 core_clk_i = ~core_clk_i;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic rnd8(output logic [7:0] r);
    seed = xs(seed);
    r = seed[7:0];
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic xfer(input logic [6:0] a, input logic s, input logic [7:0] d, input int n = 16);
    @(posedge core_clk_i);
    sbcspi_host_i.frame({d, s, a}, n, resp, err);
  endtask

  task automatic set_stat(input logic [6:0] a, input logic [7:0] b);
    @(posedge core_clk_i);
    stat_set <= '{1'b1, a, b};
    @(posedge core_clk_i);
    stat_set <= '0;
  endtask

  task automatic clr_read(input logic [6:0] a, input logic [7:0] e);
    xfer(a, 1'b1, 8'h00);
    xfer(a, 1'b0, 8'h00);
    chk("uncleared register", {e, 8'h00}, resp);
  endtask

  task automatic report_and_stop;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole run needs well under this many cycles
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    repeat (4) @(posedge core_clk_i);
    rnd8(v);
    nrst_i <= 1'b1;
    mode <= sbcspi_pkg::SBCSPI_MODE_NORMAL;
    level <= v | 8'h01;
    repeat (6) @(posedge core_clk_i);
    for (int k = 0; k < 9; k++) begin
      rnd8(v);
      v = v | 8'h01;
      set_stat(stat_addr[k], v);
      xfer(stat_addr[k], 1'b0, 8'h00);
      chk("status read", {v, 8'h01 << stat_bit[k]}, resp);
      xfer(stat_addr[k], 1'b1, 8'h00);
      chk("status clear", {v, 8'h01 << stat_bit[k]}, resp);
      xfer(stat_addr[k], 1'b0, 8'h00);
      chk("after clear", 16'h0000, resp);
    end
    rnd8(w);
    @(posedge core_clk_i);
    live_upd <= '{1'b1, 7'h70, w};
    @(posedge core_clk_i);
    live_upd <= '0;
    clr_read(7'h70, w);
    clr_read(7'h48, level);
    clr_read(7'h7e, `SBCSPI_FAMILY_VALUE);
    rnd8(v);
    xfer(7'h05, 1'b1, v);
    chk("control prior", 16'h0000, resp);
    xfer(7'h05, 1'b0, ~v);
    chk("control new", {v, 8'h00}, resp);
    chk("control copy", {8'h00, v}, {8'h00, ctrl_regs[40+:8]});
    xfer(7'h01, 1'b1, 8'h80);
    chk("mode request", 16'h0002, {14'h0000, req});
    xfer(7'h06, 1'b1, 8'h3c, 15);
    xfer(7'h06, 1'b0, 8'h00);
    chk("short frame flag", 16'h0001, {15'h0000, err});
    chk("short frame data", 16'h0000, resp);
    xfer(7'h06, 1'b0, 8'h00, 0);
    xfer(7'h06, 1'b0, 8'h00);
    chk("zero clock flag", 16'h0000, {15'h0000, err});
    rnd8(w);
    xfer(7'h14, 1'b1, w | 8'h01);
    chk("switch config", {8'h00, w | 8'h01}, {8'h00, ctrl_regs[160+:8]});
    @(posedge core_clk_i);
    mode <= sbcspi_pkg::SBCSPI_MODE_RESTART;
    repeat (10) @(posedge core_clk_i);
    chk("restart clear", 16'h0000, {8'h00, ctrl_regs[160+:8]});
    xfer(7'h05, 1'b1, ~v);
    @(posedge core_clk_i);
    mode <= sbcspi_pkg::SBCSPI_MODE_NORMAL;
    repeat (10) @(posedge core_clk_i);
    xfer(7'h05, 1'b0, 8'h00);
    chk("restart flag", 16'h0001, {15'h0000, err});
    chk("restart ignored", {8'h00, v}, {8'h00, resp[15:8]});
    xfer(7'h00, 1'b0, 8'h00);
    xfer(7'h43, 1'b0, 8'h00);
    chk("stuck word fail", 16'h0003, {14'h0000, resp[10], resp[2]});
    xfer(7'h43, 1'b1, 8'h00);
    xfer(7'h04, 1'b1, 8'h02);
    @(posedge core_clk_i);
    mode <= sbcspi_pkg::SBCSPI_MODE_STOP;
    repeat (10) @(posedge core_clk_i);
    xfer(7'h04, 1'b0, 8'h00);
    chk("stop bus control", 16'h0200, resp);
    xfer(7'h01, 1'b0, 8'h00);
    chk("stop mode field", 16'h8000, resp);
    xfer(7'h05, 1'b1, 8'h00);
    xfer(7'h05, 1'b0, 8'h00);
    chk("stop write refused", {v, 8'h04}, resp);
    @(posedge core_clk_i);
    mode <= sbcspi_pkg::SBCSPI_MODE_SLEEP;
    repeat (10) @(posedge core_clk_i);
    xfer(7'h04, 1'b0, 8'h00);
    chk("sleep bus control", 16'h0104, resp);
    xfer(7'h01, 1'b0, 8'h00);
    chk("sleep mode field", 16'h4004, resp);
    report_and_stop();
  end
endmodule
